// ---- verilog/ext_request_pin_and_reset_status.sv ----
// External request pin control/status and reset cause register.
// Assumes an AHB-Lite master, single word transfers, one slave on hready.
`timescale 1ns/1ps

// Overview of operation
// RULE1 - Pull disable bit turns pull-up off
// RULE2 - Pin enable bit allows pin requests
// RULE3 - Event flag set on detected request
// RULE4 - Writing one to acknowledge clears flag
// RULE5 - Level mode: held-low pin blocks acknowledge
// RULE6 - Interrupt enable drives request from flag
// RULE7 - Mode bit: falling edge or edge-and-level
// RULE8 - Software writes zero to reserved bit
// RULE9 - Reset cause register is read only
// RULE10 - Debug forced reset clears all causes
// RULE11 - Write restarts watchdog, keeps flags
// RULE12 - Power-on sets power and voltage flags
// RULE13 - Low voltage sets voltage, keeps power
// RULE14 - Other resets capture active sources only
// RULE15 - Pin flag marks external pin reset
// RULE16 - Watchdog flag, blocked when disabled
// RULE17 - Illegal opcode flag incl. stop/background
// RULE18 - Illegal address flag on unimplemented access
// RULE19 - Pin synchronised before edge detection
module ext_request_pin_and_reset_status
  import ext_request_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  // AHB-Lite slave
  input  wire logic                        hsel_i,
  input  wire logic [7:0]                  haddr_i,
  input  wire logic [1:0]                  htrans_i,
  input  wire logic                        hwrite_i,
  input  wire logic [2:0]                  hsize_i,
  input  wire logic [31:0]                 hwdata_i,
  input  wire logic                        hready_i,
  output logic      [31:0]                 hrdata_o,
  output logic                             hreadyout_o,
  output logic                             hresp_o,
  // Request pin, active low
  input  wire logic                        request_pin_n_i,
  output logic                             pull_up_enable_o,
  // Reset cause inputs
  input  wire ext_request_pkg::reset_sources_t reset_sources_i,
  input  wire logic                        watchdog_enable_option_i,
  input  wire logic                        stop_enable_option_i,
  input  wire logic                        background_mode_enable_i,
  // Outputs toward core and system
  output logic                             interrupt_request_o,
  output logic                             watchdog_restart_o,
  output logic                             debug_force_reset_o
);
  import ext_request_pkg::*;

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic       wr_pend_r;
  logic       rd_pend_r;
  logic [7:0] addr_r;
  logic       access;
  assign access = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);

  // Every transfer completes with no wait state
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end
    else
    begin
      wr_pend_r <= access && hwrite_i;
      rd_pend_r <= access && !hwrite_i;
      if (access)
        addr_r <= haddr_i;
    end
  end

  logic wr_ctrl;
  logic wr_cause;
  logic wr_force;
  assign wr_ctrl  = wr_pend_r && (addr_r == ADDR_CTRL_STATUS);
  assign wr_cause = wr_pend_r && (addr_r == ADDR_RESET_CAUSE);
  assign wr_force = wr_pend_r && (addr_r == ADDR_DEBUG_FORCE);

  // ----------------------------------------------------------------
  // Request pin synchroniser and detection
  // ----------------------------------------------------------------
  logic sync1_r;
  logic sync2_r;
  logic pin_prev_r;

  // Two stages; only the second is looked at
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sync1_r    <= 1'b1;
      sync2_r    <= 1'b1;
      pin_prev_r <= 1'b1;
    end
    else
    begin
      sync1_r    <= request_pin_n_i; // RULE19
      sync2_r    <= sync1_r;
      pin_prev_r <= sync2_r;
    end
  end

  logic [7:0] ctrl_r;
  logic       event_flag_r;
  logic       pin_low;
  logic       fall_edge;
  logic       detect;
  logic       ack;
  assign pin_low   = ctrl_r[BIT_PIN_ENABLE] && !sync2_r;
  assign fall_edge = ctrl_r[BIT_PIN_ENABLE] && pin_prev_r && !sync2_r; // RULE19
  // Level mode keeps detecting while the pin stays low
  assign detect    = fall_edge || (ctrl_r[BIT_DETECT_MODE] && pin_low); // RULE7 RULE2
  assign ack       = wr_ctrl && hwdata_i[BIT_EVENT_ACK]; // RULE4

  // Control bits; flag, ack and reserved bit are not stored
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ctrl_r <= CTRL_RESET_VALUE;
    else if (wr_ctrl)
    begin
      ctrl_r                   <= 8'h00;
      ctrl_r[BIT_PULL_DISABLE] <= hwdata_i[BIT_PULL_DISABLE];
      ctrl_r[BIT_PIN_ENABLE]   <= hwdata_i[BIT_PIN_ENABLE];
      ctrl_r[BIT_INT_ENABLE]   <= hwdata_i[BIT_INT_ENABLE];
      ctrl_r[BIT_DETECT_MODE]  <= hwdata_i[BIT_DETECT_MODE];
    end
  end

  // Set wins over acknowledge, so in level mode a held low level also blocks it
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      event_flag_r <= 1'b0;
    else if (detect)
      event_flag_r <= 1'b1; // RULE3 RULE5
    else if (ack)
      event_flag_r <= 1'b0; // RULE4
  end

  // Interrupt and pull-up outputs
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      interrupt_request_o <= 1'b0;
      pull_up_enable_o    <= 1'b0;
    end
    else
    begin
      interrupt_request_o <= (event_flag_r || detect) && ctrl_r[BIT_INT_ENABLE]; // RULE6
      pull_up_enable_o    <= ctrl_r[BIT_PIN_ENABLE] && !ctrl_r[BIT_PULL_DISABLE]; // RULE1
    end
  end

  // ----------------------------------------------------------------
  // Reset cause capture
  // ----------------------------------------------------------------
  logic [7:0] cause_r;
  logic [7:0] cause_nxt;
  logic       capture_r;

  // Sources are qualified by the options that block them
  always_comb
  begin
    cause_nxt = 8'h00;
    if (reset_sources_i.power_on)
      cause_nxt = CAUSE_POWER_ON_VAL; // RULE12
    else if (reset_sources_i.low_voltage)
    begin
      cause_nxt                 = CAUSE_LOW_VOLT_VAL; // RULE13
      cause_nxt[BIT_POWER_ON]   = cause_r[BIT_POWER_ON];
    end
    else
    begin
      cause_nxt[BIT_PIN_RESET]    = reset_sources_i.pin; // RULE14 RULE15
      cause_nxt[BIT_WATCHDOG]     = reset_sources_i.watchdog && watchdog_enable_option_i; // RULE16
      cause_nxt[BIT_ILLEGAL_OP]   = reset_sources_i.illegal_opcode; // RULE17
      cause_nxt[BIT_ILLEGAL_ADDR] = reset_sources_i.illegal_address; // RULE18
    end
  end

  // Capture one cycle after reset release; a forced reset clears all
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      capture_r <= 1'b1;
    else
      capture_r <= 1'b0;
  end

  // No reset branch: the flags must survive the reset they describe
  always_ff @(posedge clk_i)
  begin
    if (!reset_i)
    begin
      if (wr_force && hwdata_i[0])
        cause_r <= 8'h00; // RULE10
      else if (capture_r)
        cause_r <= cause_nxt; // RULE9 RULE13
    end
  end

  // The stop/background options only gate the core's opcode decode
  logic unused_opts;
  assign unused_opts = stop_enable_option_i ^ background_mode_enable_i ^ (|hsize_i);

  // Watchdog restart and debug reset pulses
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      watchdog_restart_o  <= 1'b0;
      debug_force_reset_o <= 1'b0;
    end
    else
    begin
      watchdog_restart_o  <= wr_cause; // RULE11
      debug_force_reset_o <= wr_force && hwdata_i[0];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] ctrl_view;
  always_comb
  begin
    ctrl_view                 = ctrl_r;
    ctrl_view[BIT_EVENT_FLAG] = event_flag_r; // RULE3
    ctrl_view[BIT_EVENT_ACK]  = 1'b0; // RULE4
    ctrl_view[BIT_RESERVED]   = 1'b0;
  end

  // Read data registered in address phase so it stands in data phase
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      hrdata_o <= 32'h00000000;
    else if (access && !hwrite_i)
    begin
      case (haddr_i)
        ADDR_CTRL_STATUS:  hrdata_o <= {24'h000000, ctrl_view};
        ADDR_RESET_CAUSE:  hrdata_o <= {24'h000000, cause_r};
        ADDR_RESET_SOURCE: hrdata_o <= {24'h000000, cause_nxt};
        default:           hrdata_o <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_clears: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
    ack && !detect |=> !event_flag_r) else $error("ack did not clear flag");
  a_level_holds: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
    ctrl_r[BIT_DETECT_MODE] && pin_low |=> event_flag_r) else $error("level lost flag");
  a_edge_sets: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
    fall_edge |=> event_flag_r) else $error("edge not flagged");
  a_irq_follows: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
    event_flag_r && ctrl_r[BIT_INT_ENABLE] |=> interrupt_request_o) else $error("irq missing");
  a_pull_off: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
    ctrl_r[BIT_PULL_DISABLE] |=> !pull_up_enable_o) else $error("pull not off");
  a_pin_disabled: assert property (@(posedge clk_i) disable iff (reset_i) // RULE2
    !ctrl_r[BIT_PIN_ENABLE] |-> !detect) else $error("disabled pin detected");
  a_wdog_restart: assert property (@(posedge clk_i) disable iff (reset_i) // RULE11
    wr_cause && !capture_r |=> watchdog_restart_o && $stable(cause_r)) else $error("restart wrong");
  a_force_clears: assert property (@(posedge clk_i) disable iff (reset_i) // RULE10
    wr_force && hwdata_i[0] |=> cause_r == 8'h00) else $error("force not cleared");
  a_power_on: assert property (@(posedge clk_i) disable iff (reset_i) // RULE12
    capture_r && reset_sources_i.power_on |=> cause_r == CAUSE_POWER_ON_VAL) else $error("por cause");
  a_wdog_block: assert property (@(posedge clk_i) disable iff (reset_i) // RULE16
    !watchdog_enable_option_i |-> !cause_nxt[BIT_WATCHDOG]) else $error("watchdog not blocked");

  // ----------------------------------------------------------------
  // Assertions: acknowledge, masking and pull-up
  // ----------------------------------------------------------------
  // A clear interrupt enable leaves the core to poll the flag
  a_irq_masked: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
    !ctrl_r[BIT_INT_ENABLE] |=> !interrupt_request_o) else $error("irq while masked");
  // Enabled pin with pull disable clear keeps the pull-up on
  a_pull_on: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
    ctrl_r[BIT_PIN_ENABLE] && !ctrl_r[BIT_PULL_DISABLE] |=> pull_up_enable_o) else $error("pull not on");
  // Edge mode: acknowledge wins even with the pin still low
  a_edge_ack: assert property (@(posedge clk_i) disable iff (reset_i) // RULE7
    ack && !ctrl_r[BIT_DETECT_MODE] && !fall_edge |=> !event_flag_r) else $error("edge ack failed");
  // Level mode: a held low level defeats the acknowledge
  a_level_ack: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
    ack && ctrl_r[BIT_DETECT_MODE] && pin_low |=> event_flag_r) else $error("level ack cleared");
  // Nothing but a detection may raise the flag
  a_flag_idle: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
    !event_flag_r && !detect |=> !event_flag_r) else $error("flag set with no event");

  // ----------------------------------------------------------------
  // Assertions: reset cause capture and hold
  // ----------------------------------------------------------------
  // Capture of a reset that is neither power-on nor low voltage
  logic other_reset;
  assign other_reset = capture_r && !reset_sources_i.power_on && !reset_sources_i.low_voltage;

  // Low voltage sets its own flag and leaves power-on as it was
  a_low_volt: assert property (@(posedge clk_i) disable iff (reset_i) // RULE13
    capture_r && !reset_sources_i.power_on && reset_sources_i.low_voltage
    |=> cause_r[BIT_LOW_VOLTAGE] && (cause_r[BIT_POWER_ON] == $past(cause_r[BIT_POWER_ON])))
    else $error("low voltage cause");
  // Between captures only a forced clear may touch the flags
  a_cause_holds: assert property (@(posedge clk_i) disable iff (reset_i) // RULE9
    !capture_r && !(wr_force && hwdata_i[0]) |=> $stable(cause_r)) else $error("cause changed");
  // Other resets copy each active source, the watchdog only with its option set, and drop the rest
  a_pin_cause: assert property (@(posedge clk_i) disable iff (reset_i) // RULE15
    other_reset |=> cause_r[BIT_PIN_RESET] == $past(reset_sources_i.pin)) else $error("pin cause");
  a_wdog_cause: assert property (@(posedge clk_i) disable iff (reset_i) // RULE16
    other_reset |=> cause_r[BIT_WATCHDOG] == ($past(reset_sources_i.watchdog) && $past(watchdog_enable_option_i)))
    else $error("watchdog cause");
  a_opcode_cause: assert property (@(posedge clk_i) disable iff (reset_i) // RULE17
    other_reset |=> cause_r[BIT_ILLEGAL_OP] == $past(reset_sources_i.illegal_opcode))
    else $error("opcode cause");
  a_addr_cause: assert property (@(posedge clk_i) disable iff (reset_i) // RULE18
    other_reset |=> cause_r[BIT_ILLEGAL_ADDR] == $past(reset_sources_i.illegal_address))
    else $error("address cause");
  // Other resets also drop the power-on and low voltage flags
  a_other_clears: assert property (@(posedge clk_i) disable iff (reset_i) // RULE14
    other_reset |=> !cause_r[BIT_POWER_ON] && !cause_r[BIT_LOW_VOLTAGE]) else $error("stale power cause");
  // Bus side effects of the cause and force registers
  a_force_pulse: assert property (@(posedge clk_i) disable iff (reset_i) // RULE10
    wr_force && hwdata_i[0] |=> debug_force_reset_o) else $error("no force pulse");
  a_restart_only: assert property (@(posedge clk_i) disable iff (reset_i) // RULE11
    !wr_cause |=> !watchdog_restart_o) else $error("stray restart");
endmodule // ext_request_pin_and_reset_status

// ---- verilog/ext_request_pkg.sv ----
// Package for the external request pin and reset cause block.
// Assumes an AHB-Lite master with 32-bit single word transfers.
package ext_request_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_RESET_CAUSE  = 8'h04;
  localparam logic [7:0] ADDR_RESET_SOURCE = 8'h08;
  localparam logic [7:0] ADDR_DEBUG_FORCE  = 8'h0c;
  // ----------------------------------------------------------------
  // Control and status field positions
  // ----------------------------------------------------------------
  localparam int BIT_PULL_DISABLE = 6;
  localparam int BIT_RESERVED     = 5;
  localparam int BIT_PIN_ENABLE   = 4;
  localparam int BIT_EVENT_FLAG   = 3;
  localparam int BIT_EVENT_ACK    = 2;
  localparam int BIT_INT_ENABLE   = 1;
  localparam int BIT_DETECT_MODE  = 0;
  // ----------------------------------------------------------------
  // Reset cause field positions
  // ----------------------------------------------------------------
  localparam int BIT_POWER_ON     = 7;
  localparam int BIT_PIN_RESET    = 6;
  localparam int BIT_WATCHDOG     = 5;
  localparam int BIT_ILLEGAL_OP   = 4;
  localparam int BIT_ILLEGAL_ADDR = 3;
  localparam int BIT_LOW_VOLTAGE  = 1;
  // ----------------------------------------------------------------
  // Reset values and bus transfer type
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET_VALUE   = 8'h00;
  localparam logic [7:0] CAUSE_POWER_ON_VAL = 8'h82;
  localparam logic [7:0] CAUSE_LOW_VOLT_VAL = 8'h02;
  localparam logic [1:0] HTRANS_NONSEQ      = 2'h2;

  // Reset sources sampled at the first clock edge after reset release
  typedef struct packed {
    logic power_on;
    logic low_voltage;
    logic pin;
    logic watchdog;
    logic illegal_opcode;
    logic illegal_address;
  } reset_sources_t;
endpackage

// ---- bench/request_source_model.sv ----
// Far-side model: source that pulls the active-low request pin.
// Assumes the device pull-up output and a bench command to pull low.
`timescale 1ns/1ps
module request_source_model
(
  // Clock and command
  input  wire logic clk_i,
  input  wire logic pull_up_enable_i,
  input  wire logic drive_low_i,
  // Pin toward device
  output logic      request_pin_n_o
);
  logic float_r = 1'b0;
  // Released and unpulled: the pin wanders, never a clean level
  always_ff @(posedge clk_i)
    float_r <= ~float_r;
  // Driven low wins; else pull-up or a floating pattern
  assign request_pin_n_o = drive_low_i ? 1'b0 : (pull_up_enable_i ? 1'b1 : float_r);
endmodule // request_source_model

// ---- bench/test_ext_request_pin_and_reset_status.sv ----
// Bench for the request pin control and reset cause registers.
// Assumes zero-wait AHB-Lite slave, pin model on the request input.
`timescale 1ns/1ps
module test_ext_request_pin_and_reset_status;
  import ext_request_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, src_low = 1'b0, wd_opt = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic hready, hresp, pin_n, pull_up, irq, wd_restart, dbg_force;
  reset_sources_t sources = '0;
  int err_total = 0, comparisons = 0, cycles = 0, wd_pulses = 0, dbg_pulses = 0;
  // Reset table: {power_on,low_voltage,pin,watchdog,illegal_opcode,illegal_address}
  logic [5:0] src_tab [6] = '{6'h30, 6'h10, 6'h0c, 6'h06, 6'h01, 6'h10};
  logic opt_tab [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [7:0] exp_tab [6] = '{8'h82, 8'h82, 8'h60, 8'h10, 8'h08, 8'h02};

  initial forever #4 clk_i = ~clk_i;

  ext_request_pin_and_reset_status dut (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .request_pin_n_i(pin_n), .pull_up_enable_o(pull_up),
    .reset_sources_i(sources), .watchdog_enable_option_i(wd_opt), .stop_enable_option_i(1'b1),
    .background_mode_enable_i(1'b1), .interrupt_request_o(irq),
    .watchdog_restart_o(wd_restart), .debug_force_reset_o(dbg_force));

  request_source_model source (.clk_i(clk_i), .pull_up_enable_i(pull_up),
    .drive_low_i(src_low), .request_pin_n_o(pin_n));

  // Pulse counters and hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (wd_restart === 1'b1) wd_pulses++;
    if (dbg_force === 1'b1) dbg_pulses++;
    if (cycles == 5000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Waits for hready sampled high at a rising edge
  task automatic wait_ready();
    do @(posedge clk_i); while (hready !== 1'b1);
  endtask

  // Single word transfer; read data taken at the data-phase edge
  task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rdata);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= is_wr;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rdata = hrdata;
    chk({31'h0, hresp}, 32'h0);
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    xfer(1'b0, a, 32'h0, got);
    chk(got, exp);
  endtask

  task automatic do_reset(input logic [5:0] s, input logic o);
    @(posedge clk_i);
    reset_i <= 1'b1;
    sources <= reset_sources_t'(s);
    wd_opt <= o;
    tick(16);
    reset_i <= 1'b0;
    tick(2);
    sources <= '0;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 6; i++)
    begin
      do_reset(src_tab[i], opt_tab[i]);
      rd(ADDR_RESET_CAUSE, {24'h0, exp_tab[i]});
    end
    $display("test reset causes done");
    rd(ADDR_CTRL_STATUS, 32'h0);
    wr(ADDR_RESET_CAUSE, 32'hff);
    rd(ADDR_RESET_CAUSE, 32'h02);
    chk(wd_pulses, 1);
    rd(8'h10, 32'h0);
    sources <= reset_sources_t'(6'h08);
    rd(ADDR_RESET_SOURCE, 32'h40);
    sources <= '0;
    $display("test cause write done");
    wr(ADDR_CTRL_STATUS, 32'h50);
    tick(2);
    chk(pull_up, 0);
    wr(ADDR_CTRL_STATUS, 32'h10);
    tick(8);
    chk(pull_up, 1);
    wr(ADDR_CTRL_STATUS, 32'h14);
    rd(ADDR_CTRL_STATUS, 32'h10);
    $display("test pull-up done");
    // Edge mode: acknowledge clears even with the pin still low
    wr(ADDR_CTRL_STATUS, 32'h12);
    src_low <= 1'b1;
    tick(8);
    rd(ADDR_CTRL_STATUS, 32'h1a);
    chk(irq, 1);
    wr(ADDR_CTRL_STATUS, 32'h16);
    rd(ADDR_CTRL_STATUS, 32'h12);
    chk(irq, 0);
    src_low <= 1'b0;
    $display("test edge mode done");
    // Level mode: a held-low pin defeats the acknowledge
    wr(ADDR_CTRL_STATUS, 32'h13);
    src_low <= 1'b1;
    tick(8);
    wr(ADDR_CTRL_STATUS, 32'h17);
    rd(ADDR_CTRL_STATUS, 32'h1b);
    src_low <= 1'b0;
    tick(8);
    wr(ADDR_CTRL_STATUS, 32'h17);
    rd(ADDR_CTRL_STATUS, 32'h13);
    $display("test level mode done");
    // Polling: flag without interrupt
    wr(ADDR_CTRL_STATUS, 32'h10);
    src_low <= 1'b1;
    tick(8);
    chk(irq, 0);
    rd(ADDR_CTRL_STATUS, 32'h18);
    src_low <= 1'b0;
    $display("test polling done");
    wr(ADDR_DEBUG_FORCE, 32'h1);
    rd(ADDR_RESET_CAUSE, 32'h0);
    chk(dbg_pulses, 1);
    $display("test debug force done");
    report_and_stop();
  end
endmodule // test_ext_request_pin_and_reset_status
